// *** logic/acs_pkg.sv ***
/*
 holds constants and carrier types for the converter channel sequencer.
 assumes one core clock at 50 MHz; the analog side is a SAR core driven by sampleEn/convertEn windows, with no done signal.
*/
package acs_pkg;
    localparam int CLK_MHZ = 50;
    localparam int RESULT_W = 10;
    localparam int CHAN_W = 5;
    localparam int NUM_CHAN = 32;
    localparam int SEQ_LAST = 10;
    localparam int SEQ_COUNT = 11;
    localparam int CONVERT_CYCLES = 12;
    localparam int IRQ_CYCLES = 2;
    localparam int EN_TIME_DEF = 4;
    localparam int SAMPLE_TIME_DEF = 4;
    localparam logic [RESULT_W-1:0] RESULT_RST = 10'h000;
    localparam logic [CHAN_W-1:0] CHAN_RST = 5'h00;
    // fixed divider per channel; firmware corrects, hardware does not
    localparam int DIVIDER [NUM_CHAN] = '{1, 25, 25, 1, 25, 1, 5, 1, 5, 1, 5, 1, 2, 2, 5, 3,
                                          3, 3, 2, 2, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3, 3};

    typedef enum logic [1:0]
    {
        ACS_MODE_SINGLE = 2'h0,
        ACS_MODE_ROBIN = 2'h1,
        ACS_MODE_ONCE = 2'h2
    } acs_mode_e;

    typedef enum logic [4:0]
    {
        ACS_IDLE = 5'h01,
        ACS_ENABLE = 5'h02,
        ACS_SAMPLE = 5'h04,
        ACS_CONVERT = 5'h08,
        ACS_IRQ = 5'h10
    } acs_state_e;

    typedef struct packed
    {
        logic enable;
        acs_mode_e mode;
        logic repeatConv;
        logic [CHAN_W-1:0] channel;
        logic [7:0] enTime;
        logic [7:0] sampleTime;
    } acs_cfg_s;

    typedef struct packed
    {
        logic sampleEn;
        logic convertEn;
        logic [CHAN_W-1:0] muxSel;
    } acs_ana_s;
endpackage : acs_pkg

// *** logic/acs_sequencer.sv ***
/*
 holds the converter channel sequencer: mux select, sample/convert timing, result store and done pulse.
 assumes the SAR core produces its 10-bit code bit by bit during the convert window, and cfg is
 stable from core logic (same clock).
*/
// Functional notes
// - results are 10-bit codes from selected input
// - auto readout covers eleven channels; single supported
// - one sampled value converted on request
// - results held readable by core firmware
// - voltage inputs prescaled to 1.2 V full-scale
// - current and thermal channels go undivided
// - auto readout walks channels zero through ten
// - each CC pin has fifth and half channels
// - external path current from sense pair difference
// - internal path currents selectable as channels
// - twelve convert cycles then two-cycle interrupt
// - round robin overwrites each stored result
// - one-time readout stops after last, interrupts
`timescale 1ns/1ps
module acs_sequencer
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // configuration from the core
    input wire acs_pkg::acs_cfg_s cfg,
    input wire logic startReq,
    // converter core
    output acs_pkg::acs_ana_s ana,
    input wire logic [acs_pkg::RESULT_W-1:0] sarCode,
    // results to firmware
    input wire logic [acs_pkg::CHAN_W-1:0] readChan,
    output logic [acs_pkg::RESULT_W-1:0] readData,
    output logic [acs_pkg::RESULT_W-1:0] lastResult,
    output logic doneIrq,
    output logic seqDoneIrq,
    output logic busy
);
    acs_pkg::acs_state_e state_r, state_nxt;
    logic [7:0] count_r, count_nxt;
    logic [acs_pkg::CHAN_W-1:0] chan_r, chan_nxt;
    logic [acs_pkg::RESULT_W-1:0] store_r [acs_pkg::NUM_CHAN];
    logic [acs_pkg::RESULT_W-1:0] last_r, last_nxt;
    logic seqIrq_r, seqIrq_nxt;
    // cycles spent converting, only for the window check below
    logic [3:0] convRun_r, convRun_nxt;
    logic autoMode;
    logic lastSeq;
    logic convDone;

    function automatic logic isAuto(input acs_pkg::acs_mode_e m);
        isAuto = (m == acs_pkg::ACS_MODE_ROBIN) || (m == acs_pkg::ACS_MODE_ONCE);
    endfunction : isAuto

    assign autoMode = isAuto(cfg.mode);
    assign lastSeq = (chan_r == 5'(acs_pkg::SEQ_LAST));
    // gated by enable so slot and last result never disagree on a cut conversion
    assign convDone = (state_r == acs_pkg::ACS_CONVERT) && (count_r == 8'(acs_pkg::CONVERT_CYCLES - 1))
        && cfg.enable;

    always_comb
    begin
        state_nxt = state_r;
        count_nxt = count_r + 8'h01;
        chan_nxt = chan_r;
        last_nxt = last_r;
        seqIrq_nxt = 1'b0;
        convRun_nxt = (state_r == acs_pkg::ACS_CONVERT) ? (convRun_r + 4'h1) : 4'h0;
        if (!cfg.enable)
        begin
            state_nxt = acs_pkg::ACS_IDLE;
            count_nxt = 8'h00;
        end
        else
        begin
            case (state_r)
                acs_pkg::ACS_IDLE:
                begin
                    count_nxt = 8'h00;
                    if (startReq)
                    begin
                        state_nxt = acs_pkg::ACS_ENABLE;
                        // auto modes start at the first sequenced channel
                        chan_nxt = autoMode ? acs_pkg::CHAN_RST : cfg.channel;
                    end
                end
                acs_pkg::ACS_ENABLE:
                begin
                    if (count_r >= cfg.enTime)
                    begin
                        state_nxt = acs_pkg::ACS_SAMPLE;
                        count_nxt = 8'h00;
                    end
                end
                acs_pkg::ACS_SAMPLE:
                begin
                    if (count_r >= cfg.sampleTime)
                    begin
                        state_nxt = acs_pkg::ACS_CONVERT;
                        count_nxt = 8'h00;
                    end
                end
                acs_pkg::ACS_CONVERT:
                begin
                    if (convDone)
                    begin
                        state_nxt = acs_pkg::ACS_IRQ;
                        count_nxt = 8'h00;
                        last_nxt = sarCode;
                        if ((cfg.mode == acs_pkg::ACS_MODE_ONCE) && lastSeq)
                        begin
                            seqIrq_nxt = 1'b1;
                        end
                    end
                end
                acs_pkg::ACS_IRQ:
                begin
                    if (count_r == 8'(acs_pkg::IRQ_CYCLES - 1))
                    begin
                        count_nxt = 8'h00;
                        state_nxt = acs_pkg::ACS_IDLE;
                        if (cfg.mode == acs_pkg::ACS_MODE_SINGLE)
                        begin
                            if (cfg.repeatConv)
                            begin
                                state_nxt = acs_pkg::ACS_SAMPLE;
                            end
                        end
                        else if (!lastSeq)
                        begin
                            state_nxt = acs_pkg::ACS_SAMPLE;
                            chan_nxt = chan_r + 5'h01;
                        end
                        else if (cfg.mode == acs_pkg::ACS_MODE_ROBIN)
                        begin
                            state_nxt = acs_pkg::ACS_SAMPLE;
                            chan_nxt = acs_pkg::CHAN_RST;
                        end
                    end
                end
                default:
                begin
                    state_nxt = acs_pkg::ACS_IDLE;
                    count_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= acs_pkg::ACS_IDLE;
            count_r <= 8'h00;
            chan_r <= acs_pkg::CHAN_RST;
            last_r <= acs_pkg::RESULT_RST;
            seqIrq_r <= 1'b0;
            convRun_r <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            chan_r <= chan_nxt;
            last_r <= last_nxt;
            seqIrq_r <= seqIrq_nxt;
            convRun_r <= convRun_nxt;
        end
    end

    // one result slot per channel; newest conversion overwrites
    genvar g;
    generate
        for (g = 0; g < acs_pkg::NUM_CHAN; g++)
        begin : gSlot
            logic [acs_pkg::RESULT_W-1:0] slot_nxt;
            always_comb
            begin
                slot_nxt = store_r[g];
                if (convDone && (chan_r == 5'(g)))
                begin
                    slot_nxt = sarCode;
                end
            end
            always_ff @(posedge core_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    store_r[g] <= acs_pkg::RESULT_RST;
                end
                else
                begin
                    store_r[g] <= slot_nxt;
                end
            end
        end
    endgenerate

    // scaling and the sense-pair difference for path currents live in the mux
    assign ana.muxSel = chan_r;
    assign ana.sampleEn = (state_r == acs_pkg::ACS_SAMPLE);
    assign ana.convertEn = (state_r == acs_pkg::ACS_CONVERT);
    assign readData = store_r[readChan];
    assign lastResult = last_r;
    assign doneIrq = (state_r == acs_pkg::ACS_IRQ);
    assign seqDoneIrq = seqIrq_r;
    assign busy = (state_r != acs_pkg::ACS_IDLE);

    chk_irq_two_cycles: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(doneIrq) |-> doneIrq [*2] ##1 !doneIrq)
        else $error("done interrupt not two cycles");

    sequence convEnd;
        !ana.convertEn && doneIrq && (convRun_r == 4'(acs_pkg::CONVERT_CYCLES));
    endsequence

    chk_convert_twelve: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(ana.convertEn) && cfg.enable && $past(cfg.enable) |-> convEnd)
        else $error("convert window not twelve cycles");

    chk_convert_bound: assert property (@(posedge core_clk) disable iff (!rst_b)
        convRun_r <= 4'(acs_pkg::CONVERT_CYCLES))
        else $error("convert window ran too long");

    chk_seq_range: assert property (@(posedge core_clk) disable iff (!rst_b)
        busy && isAuto(cfg.mode) && !$rose(busy) |-> chan_r <= 5'(acs_pkg::SEQ_LAST))
        else $error("auto readout left channels zero to ten");

    chk_result_store: assert property (@(posedge core_clk) disable iff (!rst_b)
        convDone |=> store_r[$past(chan_r)] == $past(sarCode))
        else $error("result slot not overwritten");

    chk_once_stop: assert property (@(posedge core_clk) disable iff (!rst_b)
        seqDoneIrq && cfg.enable && cfg.mode == acs_pkg::ACS_MODE_ONCE |-> ##2 state_r == acs_pkg::ACS_IDLE)
        else $error("one-time readout did not stop");

    chk_raw_code: assert property (@(posedge core_clk) disable iff (!rst_b)
        convDone |=> lastResult == $past(sarCode))
        else $error("result not raw code");

    chk_single_chan: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_r == acs_pkg::ACS_IDLE && startReq && cfg.enable && cfg.mode == acs_pkg::ACS_MODE_SINGLE
        |=> ana.muxSel == $past(cfg.channel))
        else $error("single channel not selected");

    chk_seq_irq_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
        seqDoneIrq |=> !seqDoneIrq)
        else $error("sequence interrupt not one pulse");
endmodule : acs_sequencer

// *** verification/acs_sar_model.sv ***
/*
 holds a behavioural SAR converter core facing the sequencer.
 assumes sampling is marked by sampleEn and the code is only valid inside convertEn.
*/
`timescale 1ns/1ps
module acs_sar_model
(
    // clock
    input wire logic core_clk,
    // from sequencer and bench
    input wire acs_pkg::acs_ana_s ana,
    input wire logic [4:0] salt,
    // code back
    output logic [acs_pkg::RESULT_W-1:0] sarCode
);
    logic [acs_pkg::RESULT_W-1:0] held = 10'h000;
    logic samplePrev = 1'b0;
    always @(posedge core_clk)
    begin
        samplePrev <= ana.sampleEn;
        if (ana.sampleEn && !samplePrev)
            held <= {ana.muxSel, salt};
    end
    // inverted code outside the window, so a late sample shows up as a mismatch
    assign sarCode = ana.convertEn ? held : ~held;
endmodule : acs_sar_model

// *** verification/tb_top.sv ***
/*
 holds the self-checking bench for the channel sequencer.
 assumes the SAR model answers with {channel, salt} codes.
*/
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    acs_pkg::acs_cfg_s cfg = '0;
    logic startReq = 1'b0;
    acs_pkg::acs_ana_s ana;
    logic [9:0] sarCode, readData, lastResult;
    logic [4:0] readChan = 5'h00;
    logic [4:0] salt = 5'h00;
    logic doneIrq, seqDoneIrq, busy;
    logic robinOn = 1'b0;
    integer seed = 32'hD7D59288;
    integer num_errors = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer n, i;
    logic [4:0] ch;
    logic [4:0] chList [7] = '{5'h00, 5'h1F, 5'h03, 5'h08, 5'h0C, 5'h0D, 5'h09};
    always #10 core_clk = ~core_clk;
    acs_sequencer DUT (.core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .startReq(startReq), .ana(ana),
        .sarCode(sarCode), .readChan(readChan), .readData(readData), .lastResult(lastResult),
        .doneIrq(doneIrq), .seqDoneIrq(seqDoneIrq), .busy(busy));
    acs_sar_model SAR (.core_clk(core_clk), .ana(ana), .salt(salt), .sarCode(sarCode));
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [15:0] expV, input logic [15:0] gotV);
        n_checks++;
        if (gotV !== expV)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, expV, gotV);
        end
    endtask : chk
    function automatic logic [15:0] expCode(input logic [4:0] c, input logic [4:0] s);
        expCode = {6'h00, c, s};
    endfunction : expCode
    task automatic start_op;
        @(negedge core_clk);
        startReq = 1'b1;
        @(negedge core_clk);
        startReq = 1'b0;
    endtask : start_op
    task automatic wait_done(output integer k);
        k = 0;
        while (doneIrq !== 1'b1 && k < 400)
        begin
            @(posedge core_clk);
            #1;
            k++;
        end
    endtask : wait_done
    task automatic read_auto(input logic [4:0] s);
        for (i = 0; i <= 10; i++)
        begin
            @(negedge core_clk);
            readChan = i[4:0];
            #1;
            chk("slot", expCode(i[4:0], s), {6'h00, readData});
        end
    endtask : read_auto
    always @(posedge core_clk)
    begin
        cyc++;
        if (robinOn && ana.sampleEn === 1'b1 && ana.muxSel > 5'h0A)
            chk("robin channel", 16'h0000, {11'h000, ana.muxSel});
        if (robinOn && seqDoneIrq !== 1'b0)
            chk("robin seq irq", 16'h0000, {15'h0000, seqDoneIrq});
        if (cyc == 20000)
        begin
            num_errors++;
            $display("Error timeout expected finish seen hang");
            end_sim();
        end
    end
    initial
    begin
        repeat (12) @(negedge core_clk);
        chk("reset busy", 16'h0000, {15'h0000, busy});
        chk("reset result", 16'h0000, {6'h00, lastResult});
        rst_b = 1'b1;
        for (int t = 0; t < 10; t++)
        begin
            @(negedge core_clk);
            ch = (t < 7) ? chList[t] : 5'($random(seed));
            cfg = '{enable: 1'b1, mode: acs_pkg::ACS_MODE_SINGLE, repeatConv: 1'b0, channel: ch,
                    enTime: {6'h00, 2'($random(seed))}, sampleTime: {6'h00, 2'($random(seed))}};
            salt = 5'($random(seed));
            readChan = ch;
            start_op();
            wait_done(n);
            chk("latency", 16'(cfg.enTime + cfg.sampleTime + 15), 16'(n + 1));
            chk("last result", expCode(ch, salt), {6'h00, lastResult});
            chk("read slot", expCode(ch, salt), {6'h00, readData});
            @(posedge core_clk);
            #1;
            chk("irq second", 16'h0001, {15'h0000, doneIrq});
            @(posedge core_clk);
            #1;
            chk("irq gone", 16'h0000, {15'h0000, doneIrq});
            chk("single idle", 16'h0000, {15'h0000, busy});
        end
        $display("test single done");
        @(negedge core_clk);
        cfg.repeatConv = 1'b1;
        start_op();
        wait_done(n);
        @(negedge core_clk);
        salt = 5'h1B;
        repeat (2) @(posedge core_clk);
        #1;
        wait_done(n);
        chk("repeat gap", 16'(cfg.sampleTime + 13), 16'(n));
        chk("repeat code", expCode(ch, 5'h1B), {6'h00, lastResult});
        @(negedge core_clk);
        cfg.repeatConv = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("repeat stops", 16'h0000, {15'h0000, busy});
        $display("test repeat done");
        @(negedge core_clk);
        cfg.mode = acs_pkg::ACS_MODE_ONCE;
        salt = 5'h15;
        start_op();
        n = 0;
        while (seqDoneIrq !== 1'b1 && n < 1000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("seq irq", 16'h0001, {15'h0000, seqDoneIrq});
        chk("seq with done", 16'h0001, {15'h0000, doneIrq});
        repeat (3) @(posedge core_clk);
        #1;
        chk("once stops", 16'h0000, {15'h0000, busy});
        read_auto(5'h15);
        $display("test once done");
        @(negedge core_clk);
        cfg.mode = acs_pkg::ACS_MODE_ROBIN;
        robinOn = 1'b1;
        start_op();
        repeat (12)
        begin
            wait_done(n);
            repeat (2) @(posedge core_clk);
            #1;
        end
        @(negedge core_clk);
        salt = 5'h0A;
        repeat (13)
        begin
            wait_done(n);
            repeat (2) @(posedge core_clk);
            #1;
        end
        @(negedge core_clk);
        cfg.enable = 1'b0;
        robinOn = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("disable idle", 16'h0000, {15'h0000, busy});
        read_auto(5'h0A);
        $display("test robin done");
        end_sim();
    end
endmodule : tb_top
